// file: testbench/pcr_mgmt_model.sv
// Management master model that clocks frames onto the serial management pins
`timescale 1ns/10ps
module pcr_mgmt_model (
	input wire logic clk,
	input wire logic mdio_pin,
	output logic mdc,
	output logic mdio_drv,
	output logic mdio_en
);
	initial
	begin
		mdc = 1'b0;
		mdio_drv = 1'b1;
		mdio_en = 1'b0;
	end

	// ==========================================
	// One frame, eight clocks per bit; clock stands low between frames
	task automatic xfer(input logic rd, input logic [4:0] p, input logic [4:0] r, input logic [15:0] wd,
		output logic [15:0] rdat);
		logic [1:0] op;
		logic [63:0] b;
		op = rd ? pcr_pkg::MDIO_OP_READ : pcr_pkg::MDIO_OP_WRITE;
		b = {32'hffffffff, 2'b01, op, p, r, 2'b10, wd};
		rdat = 16'h0000;
		for (int i = 63; i >= 0; i--)
		begin
			mdc <= 1'b0;
			mdio_en <= !(rd && i < 18);
			mdio_drv <= b[i];
			repeat (4) @(negedge clk);
			mdc <= 1'b1;
			if (i < 16)
				rdat[i] = mdio_pin;
			repeat (4) @(negedge clk);
		end
		mdc <= 1'b0;
		mdio_en <= 1'b0;
		@(negedge clk);
	endtask
endmodule

// file: testbench/pcr_regs_asserts.sv
// Concurrent checks on the control-two and energy-sense register block ports
`timescale 1ns/10ps
module pcr_regs_asserts #(
	parameter logic [27:0] ED_IDLE_CYCLES = 28'h0000040
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic mdc,
	input wire logic mdio_i,
	input wire logic mdio_o,
	input wire logic mdio_oe,
	input wire logic [4:0] phy_addr,
	input wire logic clk_off_strap,
	input wire logic speed_100,
	input wire logic line_energy,
	input wire logic ed_data_event,
	input wire logic ed_error_event,
	input wire logic aux_clk_rx_sel,
	input wire logic aux_clk_oe,
	input wire logic legacy_pinout,
	input wire logic soft_reset,
	input wire logic energy_power_state,
	input wire logic ed_pulse,
	input wire logic data_threshold_hit
);
	logic mdc_q;
	logic pwr_q;
	logic [4:0] sr_cnt;
	logic [4:0] rise_cnt;
	logic [2:0] pulse_cnt;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	// ==========================================
	// Soft reset length, read drive span in clock rises, pulses per power-up
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mdc_q <= 1'b0;
			pwr_q <= 1'b0;
			sr_cnt <= 5'h00;
			rise_cnt <= 5'h00;
			pulse_cnt <= 3'h0;
		end
		else
		begin
			mdc_q <= mdc;
			pwr_q <= energy_power_state;
			sr_cnt <= soft_reset ? sr_cnt + 5'h01 : 5'h00;
			rise_cnt <= !mdio_oe ? 5'h00 : rise_cnt + 5'(mdc && !mdc_q);
			if (energy_power_state && !pwr_q)
				pulse_cnt <= 3'h0;
			else if (ed_pulse && pulse_cnt != 3'h7)
				pulse_cnt <= pulse_cnt + 3'h1;
		end
	end

	// ==========================================
	// Assertions
	a_rx_sel_speed: assert property (ce && !speed_100 |=> !aux_clk_rx_sel)
		else $error("Recovered clock selected at low speed");
	a_rx_sel_cause: assert property ($rose(aux_clk_rx_sel) |-> $past(speed_100))
		else $error("Recovered clock selected without high speed");
	a_soft_len: assert property ($fell(soft_reset) |-> sr_cnt == 5'h10)
		else $error("Soft reset pulse length wrong");
	a_soft_keeps_cfg: assert property (soft_reset && $past(soft_reset, 2) |-> $stable(legacy_pinout) && $stable(aux_clk_oe))
		else $error("Configuration changed during soft reset");
	a_burst_start: assert property ($rose(energy_power_state) |-> ##[1:3] ed_pulse)
		else $error("No pulse after power-up");
	a_pulse_gap: assert property (ed_pulse |=> (!ed_pulse) [*7])
		else $error("Pulses closer than eight cycles");
	a_burst_count: assert property (pulse_cnt <= 3'h4)
		else $error("More than four pulses after one power-up");
	a_read_span: assert property ($fell(mdio_oe) |-> rise_cnt == 5'h11)
		else $error("Read drive span not seventeen clock rises");
endmodule

bind pcr_regs pcr_regs_asserts #(.ED_IDLE_CYCLES(ED_IDLE_CYCLES)) chk_u (
	.clk(clk), .arst_n(arst_n), .ce(ce), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
	.phy_addr(phy_addr), .clk_off_strap(clk_off_strap), .speed_100(speed_100), .line_energy(line_energy),
	.ed_data_event(ed_data_event), .ed_error_event(ed_error_event), .aux_clk_rx_sel(aux_clk_rx_sel),
	.aux_clk_oe(aux_clk_oe), .legacy_pinout(legacy_pinout), .soft_reset(soft_reset),
	.energy_power_state(energy_power_state), .ed_pulse(ed_pulse), .data_threshold_hit(data_threshold_hit)
);

// file: testbench/tb_top.sv
// Self-checking bench for the control-two and energy-sense registers
`timescale 1ns/10ps
module tb_top;
	localparam logic [4:0] me = 5'h05;
	localparam logic [4:0] c2 = pcr_pkg::REG_PHY_CTRL2;
	localparam logic [4:0] ec = pcr_pkg::REG_ENERGY;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic speed_100 = 1'b1;
	logic line_energy = 1'b1;
	logic strap = 1'b1;
	logic ed_data_event = 1'b0;
	logic ed_error_event = 1'b0;
	logic mdc, mdio_i, mdio_o, mdio_oe, m_drv, m_en, rx_sel, clk_oe, legacy, soft_rst, pwr, pulse, hit;
	logic [15:0] v;
	int errors = 0;
	int comparisons = 0;
	int n;

	always #5 clk = ~clk;
	// Management data line has a pull-up when nobody drives it
	assign mdio_i = mdio_oe ? mdio_o : (m_en ? m_drv : 1'b1);

	pcr_regs #(.ED_IDLE_CYCLES(28'h0000040)) dut_u (
		.clk(clk), .arst_n(arst_n), .ce(1'b1), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o),
		.mdio_oe(mdio_oe), .phy_addr(me), .clk_off_strap(strap), .speed_100(speed_100),
		.line_energy(line_energy), .ed_data_event(ed_data_event), .ed_error_event(ed_error_event),
		.aux_clk_rx_sel(rx_sel), .aux_clk_oe(clk_oe), .legacy_pinout(legacy), .soft_reset(soft_rst),
		.energy_power_state(pwr), .ed_pulse(pulse), .data_threshold_hit(hit)
	);
	pcr_mgmt_model mgr_u (.clk(clk), .mdio_pin(mdio_i), .mdc(mdc), .mdio_drv(m_drv), .mdio_en(m_en));

	// ==========================================
	// Tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error at %0t ns: seen 0x%h expected 0x%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict;
		if (errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic wr(input logic [4:0] p, input logic [4:0] r, input logic [15:0] d);
		mgr_u.xfer(1'b0, p, r, d, v);
		repeat (6) @(negedge clk);
	endtask

	task automatic rchk(input logic [4:0] p, input logic [4:0] r, input logic [15:0] e);
		mgr_u.xfer(1'b1, p, r, 16'h0000, v);
		check(v, e);
	endtask

	task automatic blip(input logic err);
		@(negedge clk);
		ed_error_event = err;
		ed_data_event = !err;
		@(negedge clk);
		ed_error_event = 1'b0;
		ed_data_event = 1'b0;
	endtask

	task automatic count_pulses(input int c);
		n = 0;
		repeat (c)
		begin
			@(negedge clk);
			if (pulse === 1'b1)
				n++;
		end
	endtask

	// ==========================================
	// Watchdog: 25 frames of about 520 cycles plus waits, with wide margin
	initial
	begin
		#400000;
		errors++;
		print_verdict;
	end

	initial
	begin
		repeat (10) @(negedge clk);
		arst_n = 1'b1;
		repeat (10) @(negedge clk);
		check(clk_oe, 1'b0);
		rchk(me, c2, 16'h0002);
		rchk(me, ec, 16'h6011);
		rchk(me, 5'h00, 16'h0000);
		wr(me, c2, 16'hffff);
		check(soft_rst, 1'b1);
		check(legacy, 1'b1);
		check(clk_oe, 1'b0);
		check(rx_sel, 1'b1);
		repeat (20) @(negedge clk);
		check(soft_rst, 1'b0);
		rchk(me, c2, 16'h1c03);
		speed_100 = 1'b0;
		repeat (4) @(negedge clk);
		check(rx_sel, 1'b0);
		wr(5'h1f, c2, 16'h0000);
		rchk(me, c2, 16'h0000);
		check(clk_oe, 1'b1);
		wr(5'h1f, c2, 16'h0400);
		wr(5'h06, c2, 16'h0400);
		rchk(me, c2, 16'h0000);
		rchk(5'h1f, c2, 16'hffff);
		check(legacy, 1'b0);
		wr(me, ec, 16'he011);
		check(pwr, 1'b0);
		blip(1'b0);
		count_pulses(60);
		check(16'(n), 16'h0004);
		check(pwr, 1'b1);
		check(hit, 1'b1);
		rchk(me, ec, 16'he511);
		rchk(me, ec, 16'he411);
		check(hit, 1'b0);
		line_energy = 1'b0;
		repeat (8) @(negedge clk);
		check(pwr, 1'b0);
		line_energy = 1'b1;
		wr(me, ec, 16'he811);
		blip(1'b0);
		count_pulses(60);
		check(16'(n), 16'h0001);
		wr(me, ec, 16'hf811);
		check(pwr, 1'b0);
		rchk(me, ec, 16'he911);
		wr(me, ec, 16'h9011);
		check(pwr, 1'b1);
		wr(me, ec, 16'h6011);
		line_energy = 1'b0;
		blip(1'b0);
		wr(me, ec, 16'h7011);
		check(pwr, 1'b1);
		line_energy = 1'b1;
		wr(me, ec, 16'hf012);
		rchk(me, ec, 16'he112);
		blip(1'b1);
		blip(1'b0);
		repeat (100) @(negedge clk);
		blip(1'b0);
		repeat (4) @(negedge clk);
		check(pwr, 1'b0);
		rchk(me, ec, 16'he212);
		blip(1'b0);
		blip(1'b0);
		repeat (4) @(negedge clk);
		check(pwr, 1'b1);
		// Mid-run reset with the clock-off strap low
		strap = 1'b0;
		arst_n = 1'b0;
		repeat (3) @(negedge clk);
		arst_n = 1'b1;
		repeat (10) @(negedge clk);
		check(clk_oe, 1'b1);
		rchk(me, c2, 16'h0000);
		rchk(me, ec, 16'h6011);
		print_verdict;
	end
endmodule

// file: verilog/pcr_mdio_slave.sv
// Serial management frame receiver and read-data driver
`timescale 1ns/10ps
module pcr_mdio_slave (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic mdc,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe,
	input wire logic [4:0] phy_addr,
	input wire logic bcast_write_en,
	output logic rd_stb,
	output logic wr_stb,
	output logic [4:0] reg_addr,
	output logic [15:0] wr_data,
	input wire logic [15:0] rd_word
);

	logic mdc_s1;
	logic mdc_s2;
	logic mdc_s3;
	logic mdio_s1;
	logic mdio_s2;
	logic mdc_rise;
	logic [11:0] head;
	pcr_pkg::pcr_mdio_state_e state_reg;
	logic [3:0] cnt_reg;
	logic [15:0] sh_reg;
	logic is_read_reg;
	logic is_write_reg;

	// ==========================================
	// Pin synchronisers
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mdc_s1 <= 1'b0;
			mdc_s2 <= 1'b0;
			mdc_s3 <= 1'b0;
			mdio_s1 <= 1'b1;
			mdio_s2 <= 1'b1;
		end
		else if (ce)
		begin
			mdc_s1 <= mdc;
			mdc_s2 <= mdc_s1;
			mdc_s3 <= mdc_s2;
			mdio_s1 <= mdio_i;
			mdio_s2 <= mdio_s1;
		end
	end

	assign mdc_rise = mdc_s2 & ~mdc_s3;
	assign head = {sh_reg[10:0], mdio_s2};

	// ==========================================
	// Frame sequencing, one step per clock rise on the management clock
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_reg <= pcr_pkg::PCR_IDLE;
			cnt_reg <= 4'h0;
			sh_reg <= 16'h0000;
			is_read_reg <= 1'b0;
			is_write_reg <= 1'b0;
			reg_addr <= 5'h00;
			wr_data <= 16'h0000;
			rd_stb <= 1'b0;
			wr_stb <= 1'b0;
			mdio_o <= 1'b0;
			mdio_oe <= 1'b0;
		end
		else if (ce)
		begin
			rd_stb <= 1'b0;
			wr_stb <= 1'b0;
			if (mdc_rise)
			begin
				unique case (state_reg)
					pcr_pkg::PCR_IDLE:
					begin
						if (!mdio_s2)
							state_reg <= pcr_pkg::PCR_START;
					end
					pcr_pkg::PCR_START:
					begin
						cnt_reg <= 4'h0;
						state_reg <= mdio_s2 ? pcr_pkg::PCR_HEAD : pcr_pkg::PCR_IDLE;
					end
					pcr_pkg::PCR_HEAD:
					begin
						sh_reg <= {sh_reg[14:0], mdio_s2};
						cnt_reg <= cnt_reg + 4'h1;
						if (cnt_reg == pcr_pkg::MDIO_HEAD_LAST)
						begin
							is_read_reg <= head[11:10] == pcr_pkg::MDIO_OP_READ && head[9:5] == phy_addr;
							is_write_reg <= head[11:10] == pcr_pkg::MDIO_OP_WRITE &&
								(head[9:5] == phy_addr ||
								(bcast_write_en && head[9:5] == pcr_pkg::BCAST_PHY_ADDR));
							rd_stb <= head[11:10] == pcr_pkg::MDIO_OP_READ && head[9:5] == phy_addr;
							reg_addr <= head[4:0];
							cnt_reg <= 4'h0;
							state_reg <= pcr_pkg::PCR_TURN;
						end
					end
					pcr_pkg::PCR_TURN:
					begin
						cnt_reg <= 4'h1;
						if (cnt_reg == 4'h0)
						begin
							mdio_o <= 1'b0;
							mdio_oe <= is_read_reg;
						end
						else
						begin
							mdio_o <= rd_word[15];
							sh_reg <= {rd_word[14:0], 1'b0};
							cnt_reg <= 4'h0;
							state_reg <= pcr_pkg::PCR_DATA;
						end
					end
					pcr_pkg::PCR_DATA:
					begin
						if (is_read_reg)
						begin
							mdio_o <= sh_reg[15];
							sh_reg <= {sh_reg[14:0], 1'b0};
						end
						else
							sh_reg <= {sh_reg[14:0], mdio_s2};
						cnt_reg <= cnt_reg + 4'h1;
						if (cnt_reg == pcr_pkg::MDIO_DATA_LAST)
						begin
							mdio_oe <= 1'b0;
							wr_stb <= is_write_reg;
							wr_data <= {sh_reg[14:0], mdio_s2};
							state_reg <= pcr_pkg::PCR_IDLE;
						end
					end
				endcase
			end
		end
	end

endmodule

// file: verilog/pcr_pkg.sv
// Shared constants for the control-two and energy-sense management registers
package pcr_pkg;

	// ==========================================
	// Register addresses and the broadcast PHY address on the management interface
	localparam logic [4:0] REG_PHY_CTRL2 = 5'h1c;
	localparam logic [4:0] REG_ENERGY = 5'h1d;
	localparam logic [4:0] BCAST_PHY_ADDR = 5'h1f;

	// ==========================================
	// Management frame fields
	localparam logic [1:0] MDIO_OP_READ = 2'h2;
	localparam logic [1:0] MDIO_OP_WRITE = 2'h1;
	localparam logic [3:0] MDIO_HEAD_LAST = 4'hb;
	localparam logic [3:0] MDIO_DATA_LAST = 4'hf;

	// ==========================================
	// Control-two bit positions
	localparam int CTL2_RXCLK_SEL = 12;
	localparam int CTL2_BCAST_WR = 11;
	localparam int CTL2_LEGACY = 10;
	localparam int CTL2_SOFT_RST = 9;
	localparam int CTL2_CLK_OFF = 1;
	localparam int CTL2_RSVD0 = 0;

	// ==========================================
	// Energy-sense bit positions, reset values and burst pulse count
	localparam int LINE_ENERGY_MODE_ON_BIT = 15;
	localparam int AUTO_WAKE_ON_ENERGY_BIT = 14;
	localparam int AUTO_SLEEP_NO_ENERGY_BIT = 13;
	localparam int MANUAL_POWER_TOGGLE_BIT = 12;
	localparam int ED_BURST_OFF_BIT = 11;
	localparam int ED_PWR_BIT = 10;
	localparam int ED_ERR_MET_BIT = 9;
	localparam int DATA_THRESHOLD_HIT_BIT = 8;
	localparam int ED_ERR_THR_LSB = 4;
	localparam int ED_DATA_THR_LSB = 0;
	localparam logic ED_AUTO_RESET = 1'b1;
	localparam logic [3:0] ED_THR_RESET = 4'h1;
	localparam logic [2:0] ED_BURST_PULSES = 3'h4;

	// ==========================================
	// Times and derived cycle counts
	localparam longint CLK_PERIOD_NS = 10;
	localparam longint ED_IDLE_TIME_MS = 2000;
	localparam longint ED_IDLE_CYCLES = ED_IDLE_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam longint SOFT_RESET_TIME_NS = 160;
	localparam logic [4:0] SOFT_RESET_CYCLES = 5'(SOFT_RESET_TIME_NS / CLK_PERIOD_NS);
	localparam longint ED_PULSE_GAP_NS = 80;
	localparam logic [3:0] ED_PULSE_GAP_CYCLES = 4'(ED_PULSE_GAP_NS / CLK_PERIOD_NS);
	localparam logic [1:0] STRAP_SETTLE = 2'h2;

	typedef enum logic [4:0] {
		PCR_IDLE = 5'b00001,
		PCR_START = 5'b00010,
		PCR_HEAD = 5'b00100,
		PCR_TURN = 5'b01000,
		PCR_DATA = 5'b10000
	} pcr_mdio_state_e;

endpackage

// file: verilog/pcr_pulse_burst.sv
// Energy-sense data pulse burst generator
`timescale 1ns/10ps
module pcr_pulse_burst (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic start,
	input wire logic single,
	output logic pulse_out
);

	logic [2:0] left_reg;
	logic [3:0] gap_reg;

	// ==========================================
	// Burst sequencing
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			left_reg <= 3'h0;
			gap_reg <= 4'h0;
			pulse_out <= 1'b0;
		end
		else if (ce)
		begin
			if (start)
			begin
				left_reg <= single ? 3'h1 : pcr_pkg::ED_BURST_PULSES;
				gap_reg <= 4'h0;
				pulse_out <= 1'b0;
			end
			else if (left_reg != 3'h0 && gap_reg == 4'h0)
			begin
				pulse_out <= 1'b1;
				left_reg <= left_reg - 3'h1;
				gap_reg <= pcr_pkg::ED_PULSE_GAP_CYCLES - 4'h1;
			end
			else
			begin
				pulse_out <= 1'b0;
				if (gap_reg != 4'h0)
					gap_reg <= gap_reg - 4'h1;
			end
		end
	end

endmodule

// file: verilog/pcr_regs.sv
// Control-two and energy-sense management registers with their control logic
`timescale 1ns/10ps
module pcr_regs #(
	parameter logic [27:0] ED_IDLE_CYCLES = 28'(pcr_pkg::ED_IDLE_CYCLES)
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic mdc,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe,
	input wire logic [4:0] phy_addr,
	input wire logic clk_off_strap,
	input wire logic speed_100,
	input wire logic line_energy,
	input wire logic ed_data_event,
	input wire logic ed_error_event,
	output logic aux_clk_rx_sel,
	output logic aux_clk_oe,
	output logic legacy_pinout,
	output logic soft_reset,
	output logic energy_power_state,
	output logic ed_pulse,
	output logic data_threshold_hit
);

	logic rd_stb;
	logic wr_stb;
	logic [4:0] reg_addr;
	logic [15:0] wr_data;
	logic [15:0] rd_word_reg;
	logic wr_ctl2;
	logic wr_ed;
	logic rd_ed;

	logic recovered_clock_out_sel_reg;
	logic broadcast_write_accept_reg;
	logic legacy_reg;
	logic rsvd0_reg;
	logic aux_clock_pin_off_reg;
	logic [3:0] sr_cnt_reg;
	logic strap_s1;
	logic strap_s2;
	logic [1:0] strap_cnt_reg;

	logic line_energy_mode_on_reg;
	logic auto_wake_on_energy_reg;
	logic auto_sleep_no_energy_reg;
	logic manual_power_toggle_reg;
	logic pulse_burst_off_reg;
	logic [3:0] data_event_threshold_reg;
	logic [3:0] error_event_threshold_reg;
	logic energy_s1;
	logic energy_s2;
	logic [27:0] idle_cnt_reg;
	logic idle_expired;
	logic [1:0] ev_in;
	logic [3:0] thr [2];
	logic [3:0] ev_cnt_reg [2];
	logic [1:0] met_reg;
	logic [1:0] reached;
	logic burst_start_reg;
	logic power_up_now;
	logic power_down_now;

	// ==========================================
	// Management frame engine
	pcr_mdio_slave u_mdio (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.mdc(mdc),
		.mdio_i(mdio_i),
		.mdio_o(mdio_o),
		.mdio_oe(mdio_oe),
		.phy_addr(phy_addr),
		.bcast_write_en(broadcast_write_accept_reg),
		.rd_stb(rd_stb),
		.wr_stb(wr_stb),
		.reg_addr(reg_addr),
		.wr_data(wr_data),
		.rd_word(rd_word_reg)
	);

	assign wr_ctl2 = wr_stb && reg_addr == pcr_pkg::REG_PHY_CTRL2;
	assign wr_ed = wr_stb && reg_addr == pcr_pkg::REG_ENERGY;
	assign rd_ed = rd_stb && reg_addr == pcr_pkg::REG_ENERGY;

	// ==========================================
	// Read data capture; unmapped addresses read as zero
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rd_word_reg <= 16'h0000;
		else if (ce && rd_stb)
		begin
			rd_word_reg <= 16'h0000;
			if (reg_addr == pcr_pkg::REG_PHY_CTRL2)
			begin
				rd_word_reg[pcr_pkg::CTL2_RXCLK_SEL] <= recovered_clock_out_sel_reg;
				rd_word_reg[pcr_pkg::CTL2_BCAST_WR] <= broadcast_write_accept_reg;
				rd_word_reg[pcr_pkg::CTL2_LEGACY] <= legacy_reg;
				rd_word_reg[pcr_pkg::CTL2_SOFT_RST] <= soft_reset;
				rd_word_reg[pcr_pkg::CTL2_CLK_OFF] <= aux_clock_pin_off_reg;
				rd_word_reg[pcr_pkg::CTL2_RSVD0] <= rsvd0_reg;
			end
			else if (reg_addr == pcr_pkg::REG_ENERGY)
			begin
				rd_word_reg[pcr_pkg::LINE_ENERGY_MODE_ON_BIT] <= line_energy_mode_on_reg;
				rd_word_reg[pcr_pkg::AUTO_WAKE_ON_ENERGY_BIT] <= auto_wake_on_energy_reg;
				rd_word_reg[pcr_pkg::AUTO_SLEEP_NO_ENERGY_BIT] <= auto_sleep_no_energy_reg;
				rd_word_reg[pcr_pkg::MANUAL_POWER_TOGGLE_BIT] <= manual_power_toggle_reg;
				rd_word_reg[pcr_pkg::ED_BURST_OFF_BIT] <= pulse_burst_off_reg;
				rd_word_reg[pcr_pkg::ED_PWR_BIT] <= energy_power_state;
				rd_word_reg[pcr_pkg::ED_ERR_MET_BIT] <= met_reg[1];
				rd_word_reg[pcr_pkg::DATA_THRESHOLD_HIT_BIT] <= met_reg[0];
				rd_word_reg[pcr_pkg::ED_ERR_THR_LSB +: 4] <= error_event_threshold_reg;
				rd_word_reg[pcr_pkg::ED_DATA_THR_LSB +: 4] <= data_event_threshold_reg;
			end
		end
	end

	// ==========================================
	// Control-two register; bits 8:2 are never stored
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			recovered_clock_out_sel_reg <= 1'b0;
			broadcast_write_accept_reg <= 1'b0;
			legacy_reg <= 1'b0;
			rsvd0_reg <= 1'b0;
			aux_clock_pin_off_reg <= 1'b0;
			strap_s1 <= 1'b0;
			strap_s2 <= 1'b0;
			strap_cnt_reg <= 2'h0;
		end
		else if (ce)
		begin
			strap_s1 <= clk_off_strap;
			strap_s2 <= strap_s1;
			if (wr_ctl2)
			begin
				recovered_clock_out_sel_reg <= wr_data[pcr_pkg::CTL2_RXCLK_SEL];
				broadcast_write_accept_reg <= wr_data[pcr_pkg::CTL2_BCAST_WR];
				legacy_reg <= wr_data[pcr_pkg::CTL2_LEGACY];
				rsvd0_reg <= wr_data[pcr_pkg::CTL2_RSVD0];
				aux_clock_pin_off_reg <= wr_data[pcr_pkg::CTL2_CLK_OFF];
				strap_cnt_reg <= 2'h3;
			end
			else if (strap_cnt_reg == pcr_pkg::STRAP_SETTLE)
			begin
				aux_clock_pin_off_reg <= strap_s2;
				strap_cnt_reg <= 2'h3;
			end
			else if (strap_cnt_reg != 2'h3)
				strap_cnt_reg <= strap_cnt_reg + 2'h1;
		end
	end

	// ==========================================
	// Soft reset pulse; the bit reads one until the pulse ends
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			soft_reset <= 1'b0;
			sr_cnt_reg <= 4'h0;
		end
		else if (ce)
		begin
			if (wr_ctl2 && wr_data[pcr_pkg::CTL2_SOFT_RST])
			begin
				soft_reset <= 1'b1;
				sr_cnt_reg <= 4'(pcr_pkg::SOFT_RESET_CYCLES - 5'h01);
			end
			else if (sr_cnt_reg != 4'h0)
				sr_cnt_reg <= sr_cnt_reg - 4'h1;
			else
				soft_reset <= 1'b0;
		end
	end

	// ==========================================
	// Clock pin and pinout controls
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			aux_clk_rx_sel <= 1'b0;
			aux_clk_oe <= 1'b0;
			legacy_pinout <= 1'b0;
		end
		else if (ce)
		begin
			aux_clk_rx_sel <= recovered_clock_out_sel_reg & speed_100;
			aux_clk_oe <= ~aux_clock_pin_off_reg;
			legacy_pinout <= legacy_reg;
		end
	end

	// ==========================================
	// Energy-sense control fields
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			line_energy_mode_on_reg <= 1'b0;
			auto_wake_on_energy_reg <= pcr_pkg::ED_AUTO_RESET;
			auto_sleep_no_energy_reg <= pcr_pkg::ED_AUTO_RESET;
			pulse_burst_off_reg <= 1'b0;
			error_event_threshold_reg <= pcr_pkg::ED_THR_RESET;
			data_event_threshold_reg <= pcr_pkg::ED_THR_RESET;
		end
		else if (ce && wr_ed)
		begin
			line_energy_mode_on_reg <= wr_data[pcr_pkg::LINE_ENERGY_MODE_ON_BIT];
			auto_wake_on_energy_reg <= wr_data[pcr_pkg::AUTO_WAKE_ON_ENERGY_BIT];
			auto_sleep_no_energy_reg <= wr_data[pcr_pkg::AUTO_SLEEP_NO_ENERGY_BIT];
			pulse_burst_off_reg <= wr_data[pcr_pkg::ED_BURST_OFF_BIT];
			error_event_threshold_reg <= wr_data[pcr_pkg::ED_ERR_THR_LSB +: 4];
			data_event_threshold_reg <= wr_data[pcr_pkg::ED_DATA_THR_LSB +: 4];
		end
	end

	// ==========================================
	// Line energy sync and data-event idle timer
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			energy_s1 <= 1'b0;
			energy_s2 <= 1'b0;
			idle_cnt_reg <= 28'h0000000;
		end
		else if (ce)
		begin
			energy_s1 <= line_energy;
			energy_s2 <= energy_s1;
			if (ed_data_event || idle_expired)
				idle_cnt_reg <= 28'h0000000;
			else
				idle_cnt_reg <= idle_cnt_reg + 28'h0000001;
		end
	end

	assign idle_expired = idle_cnt_reg == ED_IDLE_CYCLES - 28'h0000001 && !ed_data_event;
	assign ev_in = {ed_error_event, ed_data_event};
	assign thr[0] = data_event_threshold_reg;
	assign thr[1] = error_event_threshold_reg;

	// ==========================================
	// Data (0) and error (1) event counters with read-clear met flags
	for (genvar g = 0; g < 2; g++)
	begin : g_evt
		assign reached[g] = ev_cnt_reg[g] >= thr[g];
		always_ff @(posedge clk or negedge arst_n)
		begin
			if (!arst_n)
			begin
				ev_cnt_reg[g] <= 4'h0;
				met_reg[g] <= 1'b0;
			end
			else if (ce)
			begin
				if (idle_expired || power_up_now)
					ev_cnt_reg[g] <= 4'h0;
				else if (ev_in[g] && ev_cnt_reg[g] != 4'hf)
					ev_cnt_reg[g] <= ev_cnt_reg[g] + 4'h1;
				if (reached[g])
					met_reg[g] <= 1'b1;
				else if (rd_ed)
					met_reg[g] <= 1'b0;
			end
		end
	end

	assign power_up_now = line_energy_mode_on_reg && !energy_power_state &&
		(manual_power_toggle_reg || (auto_wake_on_energy_reg && reached[0]));
	assign power_down_now = line_energy_mode_on_reg && energy_power_state &&
		(manual_power_toggle_reg || (auto_sleep_no_energy_reg && !energy_s2));

	// ==========================================
	// Energy power state machine and manual toggle
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			energy_power_state <= 1'b0;
			manual_power_toggle_reg <= 1'b0;
			burst_start_reg <= 1'b0;
		end
		else if (ce)
		begin
			burst_start_reg <= power_up_now;
			if (power_up_now)
				energy_power_state <= 1'b1;
			else if (power_down_now)
				energy_power_state <= 1'b0;
			if (wr_ed && wr_data[pcr_pkg::MANUAL_POWER_TOGGLE_BIT])
				manual_power_toggle_reg <= 1'b1;
			else
				manual_power_toggle_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			data_threshold_hit <= 1'b0;
		else if (ce)
			data_threshold_hit <= met_reg[0];
	end

	// ==========================================
	// Pulse burst on each transmitter power-up
	pcr_pulse_burst u_burst (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.start(burst_start_reg),
		.single(pulse_burst_off_reg),
		.pulse_out(ed_pulse)
	);

endmodule
